// ---- bench/boot_recovery_properties.sv ----
/* port assertions for the boot recovery block.
   assumes one core_clk domain and a synchronous rst; bound to the top module. */
`default_nettype none

module boot_recovery_properties #(
	parameter int REG_LATENCY = 2
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pins and power-up conditions
	input wire logic cs_n,
	input wire logic so_oe,
	input wire logic ctrl_init_failed,
	input wire logic nv_config_corrupt,
	input wire logic read_password_on,
	input wire logic [31:0] nv_boot_setup,
	// design state seen at the ports
	input wire logic nv_write_active,
	input wire logic nv_write_done,
	input wire logic [31:0] array_addr,
	input wire logic single_line_mode,
	input wire logic boot_read_active
);
	default clocking @(posedge core_clk); endclocking

	// reset quiets so_oe, the boot read and array_addr, an nv write included
	reset_quiet_a: assert property (
		rst |=> !so_oe && !nv_write_active && !boot_read_active && array_addr == 32'h0)
		else $error("outputs not cleared by reset");
	fault_mode_a: assert property (
		disable iff (rst) $fell(rst) && (ctrl_init_failed || nv_config_corrupt) |-> ##2 single_line_mode)
		else $error("fault did not force single-line mode");
	normal_mode_a: assert property (
		disable iff (rst) $fell(rst) && !ctrl_init_failed && !nv_config_corrupt |-> ##2 !single_line_mode)
		else $error("single-line mode without a fault");
	// only a reset may leave the fault state
	fault_holds_a: assert property (
		disable iff (rst) single_line_mode |=> single_line_mode)
		else $error("fault state left without reset");
	init_no_write_a: assert property (
		disable iff (rst) single_line_mode && ctrl_init_failed |-> !nv_write_active)
		else $error("write accepted in init failure");
	fault_no_boot_a: assert property (
		disable iff (rst) single_line_mode |-> !boot_read_active)
		else $error("boot read under a fault");
	password_no_boot_a: assert property (
		disable iff (rst) read_password_on |-> !boot_read_active)
		else $error("boot read under read password");
	// the address sits at the page start two cycles before the rise, with or without delay
	boot_page_a: assert property (
		disable iff (rst) $rose(boot_read_active)
		|-> $past(array_addr, 2) == {nv_boot_setup[31:9], 9'h0})
		else $error("boot read not at the page start");
	// sync delay allowed, then the pin is let go
	select_ends_a: assert property (
		disable iff (rst) cs_n [*6] |-> !so_oe && !boot_read_active)
		else $error("output still driven after deselect");
	write_holds_a: assert property (
		disable iff (rst) nv_write_active && !nv_write_done |=> nv_write_active)
		else $error("nv write dropped without done or reset");

	// main scenarios reached
	cover property (disable iff (rst) $rose(boot_read_active));
	cover property (disable iff (rst) $rose(nv_write_active));
	cover property (disable iff (rst) single_line_mode && ctrl_init_failed);
endmodule

bind flash_boot_recovery_automatic_boot_read boot_recovery_properties #(.REG_LATENCY(REG_LATENCY)) chk (
	.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .so_oe(so_oe),
	.ctrl_init_failed(ctrl_init_failed), .nv_config_corrupt(nv_config_corrupt),
	.read_password_on(read_password_on), .nv_boot_setup(nv_boot_setup),
	.nv_write_active(nv_write_active), .nv_write_done(nv_write_done),
	.array_addr(array_addr), .single_line_mode(single_line_mode),
	.boot_read_active(boot_read_active));

`default_nettype wire

// ---- bench/flash_boot_recovery_automatic_boot_read_test.sv ----
/* self-checking bench for the boot recovery and boot read block.
   assumes the host model on the link and a combinational array model. */
`default_nettype none

module flash_boot_recovery_automatic_boot_read_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, rst, sck, cs_n, si, so_out, so_oe, nv_write_done, nv_write_active;
	logic ctrl_init_failed, nv_config_corrupt, read_password_on, single_line_mode;
	logic boot_read_active;
	logic [2:0] block_protect_size;
	logic [31:0] nv_boot_setup, nv_write_data, array_addr, addr;
	logic [7:0] array_data, v;
	int num_errors = 0, tests_run = 0, cycles = 0;
	// init, corrupt, protection, status byte, single-line mode
	localparam logic [13:0] ROWS [4] = '{{1'h1, 1'h0, 3'h5, 8'h75, 1'h1},
		{1'h0, 1'h1, 3'h3, 8'h4d, 1'h1}, {1'h1, 1'h1, 3'h2, 8'h69, 1'h1},
		{1'h0, 1'h0, 3'h7, 8'h1c, 1'h0}};
	// boot setups: page, delay, enable
	localparam logic [31:0] SETUPS [2] = '{32'h0002_4607, 32'h0000_8001};

	flash_boot_recovery_automatic_boot_read #(.REG_LATENCY(2)) dut (
		.core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
		.so_out(so_out), .so_oe(so_oe), .ctrl_init_failed(ctrl_init_failed),
		.nv_config_corrupt(nv_config_corrupt), .nv_boot_setup(nv_boot_setup),
		.block_protect_size(block_protect_size), .read_password_on(read_password_on),
		.nv_write_active(nv_write_active), .nv_write_data(nv_write_data),
		.nv_write_done(nv_write_done), .array_addr(array_addr), .array_data(array_data),
		.single_line_mode(single_line_mode), .boot_read_active(boot_read_active));
	spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe));

	// array content is a simple function of the address
	assign array_data = array_addr[7:0] ^ array_addr[15:8];

	// core clock
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end

	// watchdog so a stuck frame cannot hang the run
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask

	// conditions are taken at release, so set them under reset
	task automatic reset_dut(input logic [5:0] cond, input logic [31:0] setup);
		@(posedge core_clk);
		#1;
		{ctrl_init_failed, nv_config_corrupt, block_protect_size, read_password_on} = cond;
		nv_boot_setup = setup;
		rst = 1'h1;
		repeat (4) @(posedge core_clk);
		#1 rst = 1'h0;
		repeat (6) @(posedge core_clk);
	endtask

	// opcode, optional address and latency, then one byte each way
	task automatic frame(input logic [7:0] op, input logic [31:0] a, input int na,
		input int gap, input logic [7:0] wd);
		host.frame_on();
		host.shift(op, 8, v);
		if (na > 0) for (int i = 3; i >= 0; i--) host.shift(a[8*i +: 8], 8, v);
		host.shift(8'h00, gap, v);
		host.shift(wd, 8, v);
		host.frame_off();
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		rst = 1'h1;
		nv_write_done = 1'h0;
		{ctrl_init_failed, nv_config_corrupt, block_protect_size, read_password_on} = 6'h0;
		nv_boot_setup = 32'h0;
		repeat (4) @(posedge core_clk);
		#1;
		check("reset outputs", 32'h0, array_addr | {so_oe, nv_write_active, boot_read_active});
		foreach (ROWS[i]) begin
			reset_dut({ROWS[i][13:9], 1'h0}, 32'h0);
			check("fault mode", ROWS[i][0], single_line_mode);
			frame(8'h05, 32'h0, 0, 0, 8'h00);
			check("status", ROWS[i][8:1], v);
		end
		// init failure: write refused, generic read of status served
		reset_dut({1'h1, 1'h0, 3'h5, 1'h0}, 32'h0);
		frame(8'h06, 32'h0, 0, 0, 8'h00);
		frame(8'h71, 32'h40, 4, 0, 8'h55);
		check("refused write", 32'h0, nv_write_active);
		frame(8'h65, 32'h0080_0000, 4, 2, 8'h00);
		check("generic status", 32'h75, v);
		// corruption: config rewrite allowed, reset aborts it
		reset_dut({1'h0, 1'h1, 3'h3, 1'h0}, 32'h0);
		frame(8'h06, 32'h0, 0, 0, 8'h00);
		frame(8'h71, 32'h40, 4, 0, 8'h0b);
		check("config write", 32'h1, nv_write_active);
		check("write data", 32'h0000_000b, nv_write_data);
		frame(8'h05, 32'h0, 0, 0, 8'h00);
		check("busy status", 32'h4d, v);
		@(posedge core_clk);
		#1 rst = 1'h1;
		@(posedge core_clk);
		#1 rst = 1'h0;
		check("aborted write", 32'h0, nv_write_active);
		// host resets, no wrap, delay chosen
		for (int k = 0; k < 2; k++) begin
			reset_dut(6'h0, SETUPS[k]);
			addr = {SETUPS[k][31:9], 9'h0};
			host.frame_on();
			host.shift(8'h00, int'(SETUPS[k][8:1]), v);
			for (int b = 0; b < 2; b++) begin
				host.shift(8'h00, 8, v);
				check("boot byte", 8'(b) ^ addr[15:8], v);
				check("boot active", 32'h1, boot_read_active);
			end
			host.frame_off();
			frame(8'h05, 32'h0, 0, 0, 8'h00);
			check("status after boot", 32'h0, v);
		end
		// normal mode write lands, reads back, ends on done
		frame(8'h06, 32'h0, 0, 0, 8'h00);
		frame(8'h71, 32'h41, 4, 0, 8'h5a);
		check("normal write data", 32'h0000_5a01, nv_write_data);
		frame(8'h05, 32'h0, 0, 0, 8'h00);
		check("busy flag", 32'h01, v);
		frame(8'h65, 32'h41, 4, 2, 8'h00);
		check("setup readback", 32'h5a, v);
		@(posedge core_clk);
		#1 nv_write_done = 1'h1;
		@(posedge core_clk);
		#1 nv_write_done = 1'h0;
		check("write done", 32'h0, nv_write_active);
		// read password blocks the boot read
		reset_dut(6'h1, SETUPS[0]);
		host.frame_on();
		host.shift(8'h00, 3, v);
		host.shift(8'h00, 8, v);
		check("boot blocked", 32'h0, {so_oe, boot_read_active});
		host.frame_off();
		conclude();
	end
endmodule

`default_nettype wire

// ---- bench/spi_host_model.sv ----
/* single-line mode 0 host: makes sck and cs_n, shifts si, samples so.
   assumes the caller spaces frames; sck rests low between frames. */
`default_nettype none

module spi_host_model (
	// link pins made by the host
	output logic sck,
	output logic cs_n,
	output logic si,
	// device answer
	input wire logic so_out,
	input wire logic so_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle link
	initial begin
		sck = 1'h0;
		cs_n = 1'h1;
		si = 1'h0;
	end

	// n bits msb first; an undriven so reads as unknown
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		for (int i = 7; i > 7 - n; i--) begin
			si = tx[i];
			#80 sck = 1'h1;
			rx[i] = so_oe ? so_out : 1'hx;
			#80 sck = 1'h0;
		end
	endtask

	// odd offset keeps the link out of phase with core_clk
	task automatic frame_on();
		#7 cs_n = 1'h0;
		#80;
	endtask

	// released data line shows no stale value
	task automatic frame_off();
		#80 cs_n = 1'h1;
		si = ~si;
		#100;
	endtask
endmodule

`default_nettype wire

// ---- rtl/boot_fault_status.sv ----
/*
 * builds the volatile status one byte, forcing the fault signatures.
 * assumes fault is fixed between resets and protection comes from nv state.
 */
`include "boot_recovery_regs.svh"
`default_nettype none

module boot_fault_status (
	// block state
	input wire boot_recovery_pkg::fault_type fault,
	input wire logic [2:0] block_protect_size,
	input wire logic write_enable_latch,
	input wire logic nv_busy,
	// assembled status byte
	output logic [7:0] status_byte
);

	// signatures override the live flags; protection bits always pass
	always_comb begin
		status_byte = 8'h00;
		status_byte[`ST_PROTECT_MSB:`ST_PROTECT_LSB] = block_protect_size;
		unique case (fault)
			boot_recovery_pkg::fault_init: begin
				status_byte[`ST_PROGRAM_ERROR] = 1'b1;
				status_byte[`ST_ERASE_ERROR] = 1'b1;
				status_byte[`ST_READY_BUSY] = 1'b1;
			end
			boot_recovery_pkg::fault_config: begin
				status_byte[`ST_PROGRAM_ERROR] = 1'b1;
				status_byte[`ST_READY_BUSY] = 1'b1;
			end
			boot_recovery_pkg::fault_none: begin
				status_byte[`ST_WRITE_ENABLE] = write_enable_latch;
				status_byte[`ST_READY_BUSY] = nv_busy;
			end
		endcase
	end

endmodule

`default_nettype wire

// ---- rtl/boot_recovery_pkg.sv ----
/*
 * types shared by the boot recovery block and its helpers.
 * assumes nothing of its surroundings.
 */
`default_nettype none

package boot_recovery_pkg;

	// fault seen at power-up or reset release
	typedef enum logic [1:0] {
		fault_none,
		fault_init,
		fault_config
	} fault_type;

	// per-frame state of the serial engine
	typedef enum logic [3:0] {
		st_idle,
		st_cmd,
		st_addr,
		st_latency,
		st_data_out,
		st_data_in,
		st_boot_delay,
		st_boot_data,
		st_ignore
	} frame_state_type;

endpackage

`default_nettype wire

// ---- rtl/boot_recovery_regs.svh ----
/*
 * constants for the boot recovery and automatic boot read block:
 * opcodes, register addresses, field positions, reset values, counts.
 * assumes it is included by bare name after the package.
 */
`ifndef BOOT_RECOVERY_REGS_SVH
`define BOOT_RECOVERY_REGS_SVH

// opcodes of the single-line commands served here
`define OP_READ_STATUS_ONE 8'h05
`define OP_GENERIC_READ 8'h65
`define OP_GENERIC_WRITE 8'h71
`define OP_WRITE_ENABLE 8'h06

// register addresses seen by the generic read and write
`define ADDR_STATUS_ONE 32'h0080_0000
`define ADDR_NV_STATUS 32'h0000_0000
`define ADDR_BOOT_SETUP 32'h0000_0040

// index of the last of four address bytes; register read latency in link cycles
`define ADDR_BYTES 2'd3
`define REG_READ_LATENCY 8'd2

// boot_read_setup field positions
`define BOOT_START_MSB 31
`define BOOT_START_LSB 9
`define BOOT_DELAY_MSB 8
`define BOOT_DELAY_LSB 1
`define BOOT_ENABLE_BIT 0
`define BOOT_SETUP_RESET 32'h0000_0000

// volatile_status_one field positions
`define ST_WP_SELECT 7
`define ST_PROGRAM_ERROR 6
`define ST_ERASE_ERROR 5
`define ST_PROTECT_MSB 4
`define ST_PROTECT_LSB 2
`define ST_WRITE_ENABLE 1
`define ST_READY_BUSY 0

`endif

// ---- rtl/flash_boot_recovery_automatic_boot_read.sv ----
/*
 * power-up fault reporting, config recovery and automatic boot read
 * for a serial nor flash, served over single-line spi mode 0.
 * assumes: sck, cs_n and si are pins from the host, sampled on core_clk
 * which runs at least eight times faster than sck; fault inputs and
 * nv_boot_setup are stable at reset release; array_data follows
 * array_addr within two core_clk cycles.
 */
// What this block does
// - init failure: single-line mode, failure signature
// - init signature: bits 6,5,0 set
// - corruption signature: bits 6,0 set, 5 clear
// - init failure: only status and generic reads
// - nv status read in failure is indeterminate
// - reset aborts nv write, back to standby
// - corruption: single-line mode, writes allowed again
// - corruption keeps existing protection scheme
// - corruption: all commands, 4-byte address, 2 latency
// - automatic_boot_read streams data on first frame
// - start page from bits 31:9
// - start delay cycles from bits 8:1
// - no automatic_boot_read under read password protection
`include "boot_recovery_regs.svh"
`default_nettype none

module flash_boot_recovery_automatic_boot_read #(
	parameter int REG_LATENCY = 2
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// serial link pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so_out,
	output logic so_oe,
	// power-up condition from the embedded controller
	input wire logic ctrl_init_failed,
	input wire logic nv_config_corrupt,
	input wire logic [31:0] nv_boot_setup,
	input wire logic [2:0] block_protect_size,
	input wire logic read_password_on,
	// nonvolatile write port
	output logic nv_write_active,
	output logic [31:0] nv_write_data,
	input wire logic nv_write_done,
	// memory array read port
	output logic [31:0] array_addr,
	input wire logic [7:0] array_data,
	// mode report
	output logic single_line_mode,
	output logic boot_read_active
);

	generate
		if (REG_LATENCY < 1 || REG_LATENCY > 255) begin : bad_latency
			$error("REG_LATENCY must be between 1 and 255");
		end
	endgenerate

	localparam logic [7:0] LAT_LAST = 8'(REG_LATENCY - 1);

	logic sck_s, cs_n_s, si_s, sck_prev, sck_rise;
	logic captured, boot_pending, boot_go, byte_done, write_hit;
	logic write_enable_latch, nv_busy;
	boot_recovery_pkg::fault_type fault;
	boot_recovery_pkg::frame_state_type state;
	logic [2:0] bit_cnt;
	logic [1:0] byte_cnt;
	logic [7:0] rx, rx_byte, tx, lat_cnt, cmd, reg_byte, volatile_status_one, boot_delay;
	logic [31:0] addr, boot_read_setup, boot_start;

	// pins cross into core_clk; cs_n idles high
	pin_sync #(
		.WIDTH(3),
		.RESET_VALUE(3'b010)
	) u_pins (
		.core_clk(core_clk),
		.rst(rst),
		.async_in({sck, cs_n, si}),
		.sync_out({sck_s, cs_n_s, si_s})
	);

	// status byte with fault signatures
	boot_fault_status u_status (
		.fault(fault),
		.block_protect_size(block_protect_size),
		.write_enable_latch(write_enable_latch),
		.nv_busy(nv_busy),
		.status_byte(volatile_status_one)
	);

	// sck edge from the synchronised copy only
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sck_prev <= 1'b0;
		end else begin
			sck_prev <= sck_s;
		end
	end

	assign sck_rise = sck_s && !sck_prev;
	assign rx_byte = {rx[6:0], si_s};
	assign byte_done = sck_rise && (bit_cnt == 3'h7) && !cs_n_s;
	assign write_hit = byte_done && (state == boot_recovery_pkg::st_data_in);

	// start page aligned to 512 bytes
	assign boot_start = {boot_read_setup[`BOOT_START_MSB:`BOOT_START_LSB], 9'h000};
	assign boot_delay = boot_read_setup[`BOOT_DELAY_MSB:`BOOT_DELAY_LSB];

	assign boot_go = boot_pending && boot_read_setup[`BOOT_ENABLE_BIT] && !read_password_on
		&& (fault == boot_recovery_pkg::fault_none);

	// fault is caught once after reset release, never self-cleared
	always_ff @(posedge core_clk) begin
		if (rst) begin
			captured <= 1'b0;
			fault <= boot_recovery_pkg::fault_none;
		end else if (!captured) begin
			captured <= 1'b1;
			// only a reset leaves a fault
			if (ctrl_init_failed) begin
				fault <= boot_recovery_pkg::fault_init;
			end else if (nv_config_corrupt) begin
				fault <= boot_recovery_pkg::fault_config;
			end
		end
	end

	assign single_line_mode = (fault != boot_recovery_pkg::fault_none);

	// generic read data; unknown addresses read zero
	always_comb begin
		reg_byte = 8'h00;
		if (addr == `ADDR_STATUS_ONE) begin
			reg_byte = volatile_status_one;
		end else if (addr == `ADDR_NV_STATUS) begin
			reg_byte = 8'h00;
		end else if (addr[31:2] == `ADDR_BOOT_SETUP >> 2
			&& fault != boot_recovery_pkg::fault_init) begin
			// failure state exposes volatile status only
			reg_byte = boot_read_setup[{addr[1:0], 3'h0} +: 8];
		end
	end

	// serial frame engine: idle is left on core_clk at frame start, later states change on sck rising edges
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= boot_recovery_pkg::st_idle;
			bit_cnt <= 3'h0;
			byte_cnt <= 2'h0;
			rx <= 8'h00;
			tx <= 8'h00;
			lat_cnt <= 8'h00;
			cmd <= 8'h00;
			addr <= 32'h0000_0000;
			array_addr <= 32'h0000_0000;
			boot_pending <= 1'b1;
		end else if (cs_n_s) begin
			// frame end; automatic_boot_read is offered on the first frame only
			if (state != boot_recovery_pkg::st_idle) begin
				boot_pending <= 1'b0;
			end
			state <= boot_recovery_pkg::st_idle;
			bit_cnt <= 3'h0;
			array_addr <= boot_start;
		end else if (state == boot_recovery_pkg::st_idle) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 2'h0;
			lat_cnt <= 8'h00;
			if (!captured) begin
				state <= boot_recovery_pkg::st_idle;
			end else if (boot_go && boot_delay == 8'h00) begin
				// no command, data from the first edge
				state <= boot_recovery_pkg::st_boot_data;
				tx <= array_data;
				array_addr <= array_addr + 32'h1;
			end else if (boot_go) begin
				state <= boot_recovery_pkg::st_boot_delay;
			end else begin
				state <= boot_recovery_pkg::st_cmd;
			end
		end else if (sck_rise) begin
			rx <= rx_byte;
			bit_cnt <= bit_cnt + 3'h1;
			unique case (state)
				boot_recovery_pkg::st_cmd: begin
					if (bit_cnt == 3'h7) begin
						cmd <= rx_byte;
						byte_cnt <= 2'h0;
						if (rx_byte == `OP_READ_STATUS_ONE) begin
							state <= boot_recovery_pkg::st_data_out;
							tx <= volatile_status_one;
						end else if (rx_byte == `OP_GENERIC_READ) begin
							state <= boot_recovery_pkg::st_addr;
						end else if (rx_byte == `OP_GENERIC_WRITE
							&& fault != boot_recovery_pkg::fault_init) begin
							state <= boot_recovery_pkg::st_addr;
						end else begin
							state <= boot_recovery_pkg::st_ignore;
						end
					end
				end
				boot_recovery_pkg::st_addr: begin
					if (bit_cnt == 3'h7) begin
						addr <= {addr[23:0], rx_byte};
						byte_cnt <= byte_cnt + 2'h1;
						if (byte_cnt == `ADDR_BYTES) begin
							if (cmd == `OP_GENERIC_READ) begin
								state <= boot_recovery_pkg::st_latency;
							end else begin
								state <= boot_recovery_pkg::st_data_in;
							end
						end
					end
				end
				boot_recovery_pkg::st_latency: begin
					// REG_LATENCY latency cycles before register data
					bit_cnt <= 3'h0;
					lat_cnt <= lat_cnt + 8'h1;
					if (lat_cnt == LAT_LAST) begin
						state <= boot_recovery_pkg::st_data_out;
						tx <= reg_byte;
					end
				end
				boot_recovery_pkg::st_data_out: begin
					// status polls repeat; register reads repeat the address
					if (bit_cnt == 3'h7) begin
						if (cmd == `OP_READ_STATUS_ONE) begin
							tx <= volatile_status_one;
						end else begin
							tx <= reg_byte;
						end
					end
				end
				boot_recovery_pkg::st_data_in: begin
					if (bit_cnt == 3'h7) begin
						state <= boot_recovery_pkg::st_ignore;
					end
				end
				boot_recovery_pkg::st_boot_delay: begin
					bit_cnt <= 3'h0;
					lat_cnt <= lat_cnt + 8'h1;
					if (lat_cnt == boot_delay - 8'h1) begin
						state <= boot_recovery_pkg::st_boot_data;
						tx <= array_data;
						array_addr <= array_addr + 32'h1;
					end
				end
				boot_recovery_pkg::st_boot_data: begin
					if (bit_cnt == 3'h7) begin
						tx <= array_data;
						array_addr <= array_addr + 32'h1;
					end
				end
				boot_recovery_pkg::st_idle, boot_recovery_pkg::st_ignore: begin
					byte_cnt <= byte_cnt;
				end
			endcase
		end
	end

	// output bit follows the bit counter; host samples on the next rise
	always_ff @(posedge core_clk) begin
		if (rst) begin
			so_out <= 1'b0;
			so_oe <= 1'b0;
			boot_read_active <= 1'b0;
		end else begin
			so_out <= tx[~bit_cnt];
			so_oe <= !cs_n_s && (state == boot_recovery_pkg::st_data_out
				|| state == boot_recovery_pkg::st_boot_data);
			boot_read_active <= !cs_n_s && (state == boot_recovery_pkg::st_boot_delay
				|| state == boot_recovery_pkg::st_boot_data);
		end
	end

	// write enable latch and nonvolatile write of boot_read_setup
	always_ff @(posedge core_clk) begin
		if (rst) begin
			// reset aborts any nv write in flight
			write_enable_latch <= 1'b0;
			nv_busy <= 1'b0;
			nv_write_data <= 32'h0000_0000;
			boot_read_setup <= `BOOT_SETUP_RESET;
		end else if (!captured) begin
			boot_read_setup <= nv_boot_setup;
		end else begin
			if (nv_busy && nv_write_done) begin
				nv_busy <= 1'b0;
			end
			if (byte_done && state == boot_recovery_pkg::st_cmd
				&& rx_byte == `OP_WRITE_ENABLE
				&& fault != boot_recovery_pkg::fault_init) begin
				write_enable_latch <= 1'b1;
			end
			// config may be rewritten after corruption
			// the read_password_on input still gates the write, block_protect_size does not
			if (write_hit && write_enable_latch && !nv_busy && !read_password_on) begin
				write_enable_latch <= 1'b0;
				if (addr[31:2] == `ADDR_BOOT_SETUP >> 2) begin
					boot_read_setup[{addr[1:0], 3'h0} +: 8] <= rx_byte;
					nv_write_data <= boot_read_setup;
					nv_write_data[{addr[1:0], 3'h0} +: 8] <= rx_byte;
					nv_busy <= 1'b1;
				end
			end
		end
	end

	assign nv_write_active = nv_busy;

endmodule

`default_nettype wire

// ---- rtl/pin_sync.sv ----
/*
 * two flip-flop synchroniser for a group of pins.
 * assumes the pins are quasi-static against core_clk and reset is synchronous.
 */
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pins and their synchronised copy
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	generate
		if (WIDTH < 1) begin : bad_width
			$error("pin_sync width must be at least one");
		end
	endgenerate

	// first stage feeds the second only
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire
